// ---- common/hpd_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hpd_regs.svh"

interface hpd_if
  import hpd_pkg::*;
#(
  parameter int AW = `HPD_AW,
  parameter int DW = `HPD_DW
);
  hpd_lvl_t          control_mode_pin;
  hpd_lvl_t          sel_lvl;
  logic              bus_style_select;
  logic              mux_select;
  logic              out_edge_select;
  logic              shift_clk;
  logic              read_strobe_n;
  logic              serial_in_line;
  logic [AW-1:0]     addr;
  logic [DW-1:0]     ad_host_o;
  logic              ad_host_oe;
  logic [DW-1:0]     ad_dev_o;
  logic              ad_dev_oe;
  logic [DW-1:0]     ad;
  logic              serial_out_o;
  logic              serial_out_oe;
  logic              serial_out_line;

  // Wire resolution, pulled high when nobody drives
  assign ad = ad_dev_oe ? ad_dev_o : (ad_host_oe ? ad_host_o : {DW{1'b1}});
  assign serial_out_line = serial_out_oe ? serial_out_o : 1'b1;

  modport dev (
    input  control_mode_pin, sel_lvl, bus_style_select, mux_select,
    input  out_edge_select, shift_clk, read_strobe_n, serial_in_line,
    input  addr, ad,
    output ad_dev_o, ad_dev_oe, serial_out_o, serial_out_oe
  );

  modport host (
    output control_mode_pin, sel_lvl, bus_style_select, mux_select,
    output out_edge_select, shift_clk, read_strobe_n, serial_in_line,
    output addr, ad_host_o, ad_host_oe,
    input  ad, serial_out_line
  );

endinterface : hpd_if

`default_nettype wire

// ---- common/hpd_pkg.sv ----
`default_nettype none

package hpd_pkg;

  // Three-level pin as seen by logic
  typedef enum logic [1:0] {
    HPD_LVL_LOW  = 2'b00,
    HPD_LVL_MID  = 2'b01,
    HPD_LVL_HIGH = 2'b10
  } hpd_lvl_t;

  typedef enum logic [1:0] {
    HPD_MODE_HW       = 2'b00,
    HPD_MODE_SERIAL   = 2'b01,
    HPD_MODE_PARALLEL = 2'b10
  } hpd_mode_t;

  typedef enum logic [1:0] {
    HPD_JIT_TX  = 2'b00,
    HPD_JIT_OFF = 2'b01,
    HPD_JIT_RX  = 2'b10
  } hpd_jit_t;

endpackage : hpd_pkg

`default_nettype wire

// ---- common/hpd_regs.svh ----
`ifndef HPD_REGS_SVH
`define HPD_REGS_SVH

// Bus widths
`define HPD_AW 6
`define HPD_DW 8

// Serial frame layout: command byte then data byte, MSB first
`define HPD_FRAME_BITS 5'h10
`define HPD_CMD_LAST   5'h07
`define HPD_DATA_FIRST 5'h08
`define HPD_LAST_BIT   5'h0F
`define HPD_OUT_FIRST  5'h09
`define HPD_RW_BIT     7

// Host timing in clk cycles, and host timer width in bits
`define HPD_SCLK_HALF 4
`define HPD_RD_GAP    16
`define HPD_PAR_HOLD  10
`define HPD_TMR_W     8

// Reset values
`define HPD_DATA_RST 8'h00
`define HPD_TPL_RST  3'h0

`endif

// ---- rtl/hpd_device.sv ----
// Operation
// RL1: Host holds select low during accesses
// RL2: Hardware mode: select level places jitter attenuator
// RL3: Serial input sampled on shift clock rising
// RL4: Output edge select picks serial output edge
// RL5: Separate-strobe multiplexed: address on latch fall
// RL6: Separate-strobe nonmultiplexed: host ties latch high
// RL7: Data-strobe multiplexed: address on strobe fall
// RL8: Data-strobe nonmultiplexed: host ties strobe high
// RL9: Hardware mode: shift pin is template MSB
// RL10: Host drives read strobe low to read; in data-strobe style the device reads with it held high
// RL11: Mode pin selects hardware, serial, parallel
// RL12: Bus style pin: low data-strobe, high separate
// RL13: Share select high means multiplexed address/data
// RL14: Shared pins serve only the decoded mode
// RL15: Select high ignores all access activity
`timescale 1ns/1ps
`default_nettype none
`include "hpd_regs.svh"

module hpd_device
  import hpd_pkg::*;
#(
  parameter int AW = `HPD_AW,
  parameter int DW = `HPD_DW
)(
  input  wire logic            clk,
  input  wire logic            nrst,
  hpd_if.dev                   link,
  output logic                 req_valid_q,
  output logic                 req_write_q,
  output logic [AW-1:0]        req_addr_q,
  output logic [DW-1:0]        req_wdata_q,
  input  wire logic [DW-1:0]   rsp_rdata,
  output hpd_mode_t            ctl_mode_q,
  output hpd_jit_t             jitter_atten_place,
  output logic [2:0]           template_sel_q
);

  localparam int PW = 9 + AW + DW;
  localparam logic [PW-1:0] PIN_RST =
    {HPD_LVL_LOW, HPD_LVL_HIGH, 2'h0, 3'h7, {(AW + DW){1'b0}}};

  // Clock-domain pin capture
  logic [PW-1:0]   pin_raw;
  logic [PW-1:0]   pin_s1_q;
  logic [PW-1:0]   pin_s2_q;
  logic [2:0]      stb_p_q;
  logic [1:0]      mode_s;
  logic [1:0]      sel_s;
  logic            style_s;
  logic            mux_s;
  logic            shift_s;
  logic            rd_s;
  logic            wr_s;
  logic [AW-1:0]   addr_s;
  logic [DW-1:0]   ad_s;

  // Parallel decode
  logic            par_on;
  logic            cs_on;
  logic            as_fall;
  logic            rd_fall;
  logic            wr_fall;
  logic            wr_rise;
  logic            p_rd;
  logic            p_wr;
  logic [AW-1:0]   addr_q;
  logic [AW-1:0]   eff_addr;
  logic [DW-1:0]   rdata_q;

  // Serial side, on the shift clock
  logic            frame_rst_n;
  logic [4:0]      cnt_q;
  logic [6:0]      sh_q;
  logic [7:0]      sbit;
  logic            srd_q;
  logic            sor_q;
  logic            sof_q;
  logic [AW-1:0]   sadr_q;
  logic [DW-1:0]   swd_q;
  logic            rtg_q;
  logic            wtg_q;

  // Toggle crossing into clk
  logic [2:0]      rtg_sync_q;
  logic [2:0]      wtg_sync_q;
  logic            ser_on;
  logic            s_rd;
  logic            s_wr;

  assign pin_raw = {link.control_mode_pin, link.sel_lvl,
                    link.bus_style_select, link.mux_select,
                    link.shift_clk, link.read_strobe_n,
                    link.serial_in_line, link.addr, link.ad};
  assign {mode_s, sel_s, style_s, mux_s, shift_s, rd_s, wr_s,
          addr_s, ad_s} = pin_s2_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= PIN_RST;
      pin_s2_q <= PIN_RST;
      stb_p_q  <= 3'h7;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      stb_p_q  <= {shift_s, rd_s, wr_s};
    end
  end

  // Mode decode and hardware-mode configuration
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_mode_q         <= HPD_MODE_HW;
      jitter_atten_place <= HPD_JIT_OFF;
      template_sel_q     <= `HPD_TPL_RST;
    end else begin
      unique case (mode_s) // [RL11]
        HPD_LVL_LOW:  ctl_mode_q <= HPD_MODE_HW;
        HPD_LVL_MID:  ctl_mode_q <= HPD_MODE_SERIAL;
        HPD_LVL_HIGH: ctl_mode_q <= HPD_MODE_PARALLEL;
        default:      ctl_mode_q <= HPD_MODE_HW;
      endcase
      if (mode_s == HPD_LVL_LOW) begin // [RL14]
        unique case (sel_s) // [RL2]
          HPD_LVL_LOW:  jitter_atten_place <= HPD_JIT_TX;
          HPD_LVL_MID:  jitter_atten_place <= HPD_JIT_OFF;
          HPD_LVL_HIGH: jitter_atten_place <= HPD_JIT_RX;
          default:      jitter_atten_place <= HPD_JIT_OFF;
        endcase
        template_sel_q <= {shift_s, rd_s, wr_s}; // [RL9]
      end
    end
  end

  // Parallel port strobe decode
  assign par_on   = (mode_s == HPD_LVL_HIGH); // [RL11]
  assign cs_on    = par_on && (sel_s == HPD_LVL_LOW); // [RL15] [RL1]
  assign as_fall  = stb_p_q[2] && !shift_s;
  assign rd_fall  = stb_p_q[1] && !rd_s;
  assign wr_fall  = stb_p_q[0] && !wr_s;
  assign wr_rise  = !stb_p_q[0] && wr_s;
  assign eff_addr = mux_s ? addr_q : addr_s; // [RL13] [RL6] [RL8]

  always_comb begin
    p_rd = 1'b0;
    p_wr = 1'b0;
    if (cs_on) begin
      if (style_s) begin // [RL12]
        p_rd = rd_fall; // [RL10]
        p_wr = wr_rise;
      end else begin
        p_rd = wr_fall && rd_s;
        p_wr = wr_rise && !rd_s;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= '0;
    end else if (cs_on && mux_s && as_fall) begin
      addr_q <= ad_s[AW-1:0]; // [RL5] [RL7]
    end
  end

  // Read data return on the shared lines
  assign link.ad_dev_o  = rdata_q;
  assign link.ad_dev_oe = cs_on && (style_s ? !rd_s : (!wr_s && rd_s));

  // Serial frame is cleared whenever select is high
  assign frame_rst_n = nrst && (link.sel_lvl == HPD_LVL_LOW) &&
                       (link.control_mode_pin == HPD_LVL_MID); // [RL15] [RL14]
  assign sbit = {sh_q, link.serial_in_line};

  always_ff @(posedge link.shift_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_q <= '0;
      sh_q  <= '0;
      srd_q <= 1'b0;
      sor_q <= 1'b0;
    end else begin
      sh_q <= sbit[6:0]; // [RL3]
      if (cnt_q != `HPD_FRAME_BITS) begin
        cnt_q <= cnt_q + 5'h01;
      end
      if (cnt_q == `HPD_CMD_LAST) begin
        srd_q <= sbit[`HPD_RW_BIT];
      end
      if (srd_q && cnt_q >= `HPD_DATA_FIRST &&
          cnt_q <= `HPD_LAST_BIT) begin
        sor_q <= rdata_q[3'(`HPD_LAST_BIT - cnt_q)]; // [RL4]
      end
    end
  end

  always_ff @(negedge link.shift_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sof_q <= 1'b0;
    end else if (srd_q && cnt_q >= `HPD_OUT_FIRST) begin
      sof_q <= rdata_q[3'(`HPD_FRAME_BITS - cnt_q)]; // [RL4]
    end
  end

  assign link.serial_out_o  = link.out_edge_select ? sor_q : sof_q; // [RL4]
  assign link.serial_out_oe = srd_q && (cnt_q >= `HPD_OUT_FIRST);

  // Command and data words held for the clk side
  always_ff @(posedge link.shift_clk or negedge nrst) begin
    if (!nrst) begin
      sadr_q <= '0;
      swd_q  <= `HPD_DATA_RST;
      rtg_q  <= 1'b0;
      wtg_q  <= 1'b0;
    end else if (frame_rst_n) begin
      if (cnt_q == `HPD_CMD_LAST) begin
        sadr_q <= sbit[AW-1:0];
        if (sbit[`HPD_RW_BIT]) begin
          rtg_q <= !rtg_q;
        end
      end
      if (cnt_q == `HPD_LAST_BIT && !srd_q) begin
        swd_q <= sbit;
        wtg_q <= !wtg_q;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rtg_sync_q <= 3'h0;
      wtg_sync_q <= 3'h0;
    end else begin
      rtg_sync_q <= {rtg_sync_q[1:0], rtg_q};
      wtg_sync_q <= {wtg_sync_q[1:0], wtg_q};
    end
  end

  assign ser_on = (mode_s == HPD_LVL_MID);
  assign s_rd   = ser_on && (rtg_sync_q[2] != rtg_sync_q[1]);
  assign s_wr   = ser_on && (wtg_sync_q[2] != wtg_sync_q[1]);

  // User-side request pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_valid_q <= 1'b0;
      req_write_q <= 1'b0;
      req_addr_q  <= '0;
      req_wdata_q <= `HPD_DATA_RST;
    end else begin
      req_valid_q <= p_rd || p_wr || s_rd || s_wr;
      if (p_rd || p_wr) begin
        req_write_q <= p_wr;
        req_addr_q  <= eff_addr;
        if (p_wr) begin
          req_wdata_q <= ad_s;
        end
      end else if (s_rd || s_wr) begin
        req_write_q <= s_wr;
        req_addr_q  <= sadr_q;
        if (s_wr) begin
          req_wdata_q <= swd_q;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= `HPD_DATA_RST;
    end else if (req_valid_q && !req_write_q) begin
      rdata_q <= rsp_rdata;
    end
  end

endmodule : hpd_device

`default_nettype wire

// ---- rtl/hpd_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hpd_regs.svh"

module hpd_host
  import hpd_pkg::*;
#(
  parameter int AW   = `HPD_AW,
  parameter int DW   = `HPD_DW,
  parameter int HALF = `HPD_SCLK_HALF,
  parameter int GAP  = `HPD_RD_GAP,
  parameter int HOLD = `HPD_PAR_HOLD
)(
  input  wire logic            clk,
  input  wire logic            nrst,
  hpd_if.host                  link,
  input  wire hpd_mode_t       cfg_mode,
  input  wire logic            cfg_bus_style,
  input  wire logic            cfg_mux,
  input  wire logic            cfg_out_edge,
  input  wire hpd_jit_t        cfg_jitter,
  input  wire logic [2:0]      cfg_template,
  input  wire logic            cmd_valid,
  output logic                 cmd_ready,
  input  wire logic            cmd_write,
  input  wire logic [AW-1:0]   cmd_addr,
  input  wire logic [DW-1:0]   cmd_wdata,
  output logic                 rsp_valid,
  output logic [DW-1:0]        rsp_rdata
);

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_SER   = 3'b001,
    HS_GAP   = 3'b010,
    HS_PADDR = 3'b011,
    HS_PLAT  = 3'b100,
    HS_PSTB  = 3'b101,
    HS_PREL  = 3'b110,
    HS_END   = 3'b111
  } hpd_hst_t;

  localparam logic [`HPD_TMR_W-1:0] T_HALF = `HPD_TMR_W'(HALF - 1);
  localparam logic [`HPD_TMR_W-1:0] T_GAP  = `HPD_TMR_W'(GAP - 1);
  localparam logic [`HPD_TMR_W-1:0] T_HOLD = `HPD_TMR_W'(HOLD - 1);

  hpd_hst_t               st_q;
  logic [`HPD_TMR_W-1:0]  tmr_q;
  logic [4:0]             edges_q;
  logic                   hi_q;
  logic                   gap_done_q;
  logic [15:0]            word_q;
  logic                   wr_q;
  logic [DW-1:0]          wdata_q;
  logic [DW-1:0]          rx_q;
  logic [1:0]             so_sync_q;
  logic [DW-1:0]          ad_s1_q;
  logic [DW-1:0]          ad_s2_q;
  logic                   stb_rd;
  logic                   stb_wr;
  logic                   stb_oe;
  logic                   rd_frame;

  assign cmd_ready = (st_q == HS_IDLE) && (cfg_mode != HPD_MODE_HW);
  assign rd_frame  = word_q[15];

  // Strobe levels for the data phase, per bus style
  always_comb begin
    if (cfg_bus_style) begin
      stb_rd = wr_q;
      stb_wr = !wr_q;
    end else begin
      stb_rd = !wr_q;
      stb_wr = 1'b0;
    end
    stb_oe = wr_q;
  end

  // Two-flop capture of device-driven lines
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      so_sync_q <= 2'h3;
      ad_s1_q   <= `HPD_DATA_RST;
      ad_s2_q   <= `HPD_DATA_RST;
    end else begin
      so_sync_q <= {so_sync_q[0], link.serial_out_line};
      ad_s1_q   <= link.ad;
      ad_s2_q   <= ad_s1_q;
    end
  end

  // Sequencer and pin drivers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q                  <= HS_IDLE;
      tmr_q                 <= '0;
      edges_q               <= '0;
      hi_q                  <= 1'b0;
      gap_done_q            <= 1'b0;
      word_q                <= '0;
      wr_q                  <= 1'b0;
      wdata_q               <= `HPD_DATA_RST;
      rx_q                  <= `HPD_DATA_RST;
      rsp_valid             <= 1'b0;
      rsp_rdata             <= `HPD_DATA_RST;
      link.control_mode_pin <= HPD_LVL_LOW;
      link.sel_lvl          <= HPD_LVL_HIGH;
      link.bus_style_select <= 1'b0;
      link.mux_select       <= 1'b0;
      link.out_edge_select  <= 1'b0;
      link.shift_clk        <= 1'b1;
      link.read_strobe_n    <= 1'b1;
      link.serial_in_line   <= 1'b1;
      link.addr             <= '0;
      link.ad_host_o        <= `HPD_DATA_RST;
      link.ad_host_oe       <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (tmr_q != '0) begin
        tmr_q <= tmr_q - `HPD_TMR_W'(1);
      end
      unique case (st_q)
        HS_IDLE: begin
          link.control_mode_pin <= hpd_lvl_t'(cfg_mode);
          link.bus_style_select <= cfg_bus_style;
          link.mux_select       <= cfg_mux;
          link.out_edge_select  <= cfg_out_edge;
          if (cfg_mode == HPD_MODE_HW) begin
            link.sel_lvl        <= hpd_lvl_t'(cfg_jitter); // [RL2]
            link.shift_clk      <= cfg_template[2]; // [RL9]
            link.read_strobe_n  <= cfg_template[1];
            link.serial_in_line <= cfg_template[0];
          end else begin
            link.sel_lvl        <= HPD_LVL_HIGH;
            link.shift_clk      <= (cfg_mode == HPD_MODE_PARALLEL); // [RL6] [RL8]
            link.read_strobe_n  <= 1'b1;
            link.serial_in_line <= 1'b1;
          end
          if (cmd_valid && cmd_ready) begin
            wr_q    <= cmd_write;
            wdata_q <= cmd_wdata;
            word_q  <= {!cmd_write, 1'b0, cmd_addr, cmd_wdata};
            link.sel_lvl <= HPD_LVL_LOW; // [RL1]
            tmr_q   <= (cfg_mode == HPD_MODE_SERIAL) ? T_HALF : T_HOLD;
            if (cfg_mode == HPD_MODE_SERIAL) begin
              link.shift_clk      <= 1'b0;
              link.serial_in_line <= !cmd_write;
              edges_q    <= '0;
              hi_q       <= 1'b0;
              gap_done_q <= 1'b0;
              st_q       <= HS_SER;
            end else begin
              link.addr       <= cmd_addr;
              link.ad_host_o  <= DW'(cmd_addr);
              link.ad_host_oe <= cfg_mux;
              st_q            <= HS_PADDR;
            end
          end
        end
        HS_SER: begin
          if (tmr_q == '0) begin
            tmr_q <= T_HALF;
            if (!hi_q) begin
              if (rd_frame && !link.out_edge_select &&
                  edges_q >= `HPD_OUT_FIRST) begin
                rx_q <= {rx_q[DW-2:0], so_sync_q[1]};
              end
              if (edges_q == `HPD_FRAME_BITS) begin
                link.sel_lvl <= HPD_LVL_HIGH;
                tmr_q        <= T_HOLD;
                rsp_valid    <= rd_frame;
                rsp_rdata    <= rx_q;
                if (!link.out_edge_select) begin
                  rsp_rdata <= {rx_q[DW-2:0], so_sync_q[1]};
                end
                st_q <= HS_END;
              end else if (rd_frame && !gap_done_q &&
                           edges_q == `HPD_DATA_FIRST) begin
                gap_done_q <= 1'b1;
                tmr_q      <= T_GAP;
                st_q       <= HS_GAP;
              end else begin
                link.shift_clk <= 1'b1;
                hi_q           <= 1'b1;
                edges_q        <= edges_q + 5'h01;
              end
            end else begin
              if (rd_frame && link.out_edge_select &&
                  edges_q >= `HPD_OUT_FIRST) begin
                rx_q <= {rx_q[DW-2:0], so_sync_q[1]};
              end
              link.shift_clk      <= 1'b0;
              hi_q                <= 1'b0;
              link.serial_in_line <= word_q[4'(`HPD_LAST_BIT - edges_q)];
            end
          end
        end
        HS_GAP: begin
          if (tmr_q == '0) begin
            st_q <= HS_SER;
          end
        end
        HS_PADDR: begin
          if (tmr_q == '0) begin
            tmr_q <= T_HOLD;
            if (link.mux_select) begin
              link.shift_clk <= 1'b0;
              st_q           <= HS_PLAT;
            end else begin
              link.read_strobe_n  <= stb_rd;
              link.serial_in_line <= stb_wr;
              link.ad_host_o      <= wdata_q;
              link.ad_host_oe     <= stb_oe;
              st_q                <= HS_PSTB;
            end
          end
        end
        HS_PLAT: begin
          if (tmr_q == '0) begin
            tmr_q               <= T_HOLD;
            link.read_strobe_n  <= stb_rd;
            link.serial_in_line <= stb_wr;
            link.ad_host_o      <= wdata_q;
            link.ad_host_oe     <= stb_oe;
            st_q                <= HS_PSTB;
          end
        end
        HS_PSTB: begin
          if (tmr_q == '0) begin
            tmr_q               <= T_HOLD;
            rx_q                <= ad_s2_q;
            // Data-strobe style keeps read/write level past strobe rise
            if (link.bus_style_select) begin
              link.read_strobe_n <= 1'b1;
            end
            link.serial_in_line <= 1'b1;
            st_q                <= HS_PREL;
          end
        end
        HS_PREL: begin
          if (tmr_q == '0) begin
            tmr_q           <= T_HOLD;
            link.ad_host_oe    <= 1'b0;
            link.read_strobe_n <= 1'b1;
            link.shift_clk     <= 1'b1;
            link.sel_lvl    <= HPD_LVL_HIGH;
            rsp_valid       <= !wr_q;
            rsp_rdata       <= rx_q;
            st_q            <= HS_END;
          end
        end
        HS_END: begin
          if (tmr_q == '0) begin
            st_q <= HS_IDLE;
          end
        end
      endcase
    end
  end

endmodule : hpd_host

`default_nettype wire

// ---- verif/hpd_link_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module hpd_link_checker
  import hpd_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire hpd_lvl_t   control_mode_pin,
  input wire hpd_lvl_t   sel_lvl,
  input wire logic       bus_style_select,
  input wire logic       out_edge_select,
  input wire logic       shift_clk,
  input wire logic       read_strobe_n,
  input wire logic       serial_in_line,
  input wire logic       ad_dev_oe,
  input wire logic       serial_out_o,
  input wire logic       serial_out_oe,
  input wire hpd_mode_t  ctl_mode_q,
  input wire hpd_jit_t   jitter_atten_place,
  input wire logic [2:0] template_sel_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [2:0] pins;
  assign pins = {shift_clk, read_strobe_n, serial_in_line};

  a_mode_decode: assert property (
    $stable(control_mode_pin) [*8] |->
    ctl_mode_q == hpd_mode_t'(control_mode_pin))
    else $error("mode decode wrong");
  a_jitter_place: assert property (
    (control_mode_pin == HPD_LVL_LOW && $stable(sel_lvl)) [*8] |->
    jitter_atten_place == hpd_jit_t'(sel_lvl))
    else $error("jitter place wrong");
  a_template_bits: assert property (
    (control_mode_pin == HPD_LVL_LOW && $stable(pins)) [*8] |->
    template_sel_q == pins)
    else $error("template bits wrong");
  a_out_edge: assert property (
    serial_out_oe && $past(serial_out_oe) &&
    serial_out_o != $past(serial_out_o) |->
    shift_clk == out_edge_select)
    else $error("serial out on wrong edge");
  a_serial_quiet: assert property (
    serial_out_oe |->
    control_mode_pin == HPD_LVL_MID && sel_lvl == HPD_LVL_LOW)
    else $error("serial out driven outside access");
  a_par_drive: assert property (
    ad_dev_oe |->
    control_mode_pin == HPD_LVL_HIGH && sel_lvl == HPD_LVL_LOW)
    else $error("bus driven outside access");
  a_read_sep: assert property (
    ad_dev_oe && bus_style_select |-> !$past(read_strobe_n, 1) ||
    !$past(read_strobe_n, 2) || !$past(read_strobe_n, 3))
    else $error("drive without read strobe");
  a_read_ds: assert property (
    ad_dev_oe && !bus_style_select |-> read_strobe_n &&
    (!$past(serial_in_line, 1) || !$past(serial_in_line, 2) ||
    !$past(serial_in_line, 3)))
    else $error("drive without data strobe");
  a_hw_quiet: assert property (
    control_mode_pin == HPD_LVL_LOW |-> !ad_dev_oe && !serial_out_oe)
    else $error("output driven in hardware mode");

  c_par_read: cover property (ad_dev_oe);
  c_ser_read: cover property (serial_out_oe);
  c_hw_rx: cover property (jitter_atten_place == HPD_JIT_RX);
endmodule : hpd_link_checker
`default_nettype wire

// ---- verif/hpd_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_decode_tb_top
  import hpd_pkg::*;
;
  logic       clk = 1'b0;
  logic       dclk = 1'b0;
  logic       nrst = 1'b0;
  hpd_mode_t  cfg_mode = HPD_MODE_HW;
  logic       cfg_bus_style = 1'b0;
  logic       cfg_mux = 1'b0;
  logic       cfg_out_edge = 1'b0;
  hpd_jit_t   cfg_jitter = HPD_JIT_OFF;
  logic [2:0] cfg_template = 3'h0;
  logic       cmd_valid = 1'b0;
  logic       cmd_write = 1'b0;
  logic [5:0] cmd_addr = 6'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic       cmd_ready, rsp_valid, req_valid_q, req_write_q;
  logic [7:0] rsp_rdata, req_wdata_q, dev_rdata;
  logic [5:0] req_addr_q;
  hpd_mode_t  ctl_mode_q;
  hpd_jit_t   jitter_atten_place;
  logic [2:0] template_sel_q;
  logic [7:0] mem [64];
  int         rq[$], dq[$];
  int         mismatches = 0;
  int         checks = 0;

  always #12.5 clk = ~clk;
  always #32 dclk = ~dclk;

  hpd_if link ();
  hpd_host #(.HALF(4), .GAP(40), .HOLD(20)) i_hpd_host (
    .clk(clk), .nrst(nrst), .link(link), .cfg_mode(cfg_mode),
    .cfg_bus_style(cfg_bus_style), .cfg_mux(cfg_mux),
    .cfg_out_edge(cfg_out_edge), .cfg_jitter(cfg_jitter),
    .cfg_template(cfg_template), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hpd_device i_hpd_device (
    .clk(dclk), .nrst(nrst), .link(link), .req_valid_q(req_valid_q),
    .req_write_q(req_write_q), .req_addr_q(req_addr_q),
    .req_wdata_q(req_wdata_q), .rsp_rdata(dev_rdata),
    .ctl_mode_q(ctl_mode_q), .jitter_atten_place(jitter_atten_place),
    .template_sel_q(template_sel_q));
  hpd_link_checker i_hpd_link_checker (
    .clk(dclk), .nrst(nrst), .control_mode_pin(link.control_mode_pin),
    .sel_lvl(link.sel_lvl), .bus_style_select(link.bus_style_select),
    .out_edge_select(link.out_edge_select), .shift_clk(link.shift_clk),
    .read_strobe_n(link.read_strobe_n),
    .serial_in_line(link.serial_in_line), .ad_dev_oe(link.ad_dev_oe),
    .serial_out_o(link.serial_out_o), .serial_out_oe(link.serial_out_oe),
    .ctl_mode_q(ctl_mode_q), .jitter_atten_place(jitter_atten_place),
    .template_sel_q(template_sel_q));
  assign dev_rdata = mem[req_addr_q];

  task automatic chk(input string nm, input logic [15:0] exp, got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Device requests and host answers against the queued model
  always @(posedge dclk) begin
    if (nrst && req_valid_q === 1'b1) begin
      chk("req", rq.size() ? 16'(rq.pop_front()) : 16'hFFFF,
          {req_write_q, 1'b0, req_addr_q,
           req_write_q ? req_wdata_q : 8'h00});
    end
  end
  always @(posedge clk) begin
    if (nrst && rsp_valid === 1'b1) begin
      chk("rdata", dq.size() ? 16'(dq.pop_front()) : 16'hFFFF,
          {8'h00, rsp_rdata});
    end
  end

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #2;
      n++;
    end
  endtask : wait_ready

  task automatic op(input logic w, input logic [5:0] a, input logic [7:0] d);
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    wait_ready();
    rq.push_back({w, 1'b0, a, w ? d : 8'h00});
    if (w) mem[a] = d;
    if (!w) dq.push_back(mem[a]);
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    wait_ready();
  endtask : op

  task automatic mode(input hpd_mode_t m, input logic st, mx, oe);
    logic [5:0] a;
    cfg_mode = m;
    cfg_bus_style = st;
    cfg_mux = mx;
    cfg_out_edge = oe;
    repeat (40) @(posedge clk);
    #2;
    chk("mode", 16'(m), 16'(ctl_mode_q));
    a = 6'($urandom);
    op(1'b1, a, 8'($urandom));
    op(1'b0, a, 8'h00);
    op(1'b0, 6'h3F, 8'h00);
    op(1'b1, 6'h00, 8'($urandom));
  endtask : mode

  task automatic hw_check();
    cfg_mode = HPD_MODE_HW;
    for (int j = 0; j < 3; j++) begin
      cfg_jitter = hpd_jit_t'(j);
      cfg_template = 3'($urandom);
      repeat (40) @(posedge clk);
      #2;
      chk("jitter", 16'(j), 16'(jitter_atten_place));
      chk("template", 16'(cfg_template), 16'(template_sel_q));
    end
    chk("mode", 16'(HPD_MODE_HW), 16'(ctl_mode_q));
  endtask : hw_check

  initial begin
    void'($urandom(32'h8c7c));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (2) @(posedge clk);
    #2;
    nrst = 1'b1;
    hw_check();
    mode(HPD_MODE_SERIAL, 1'b0, 1'b0, 1'b0);
    mode(HPD_MODE_SERIAL, 1'b0, 1'b0, 1'b1);
    mode(HPD_MODE_PARALLEL, 1'b1, 1'b1, 1'b0);
    mode(HPD_MODE_PARALLEL, 1'b1, 1'b0, 1'b0);
    mode(HPD_MODE_PARALLEL, 1'b0, 1'b1, 1'b0);
    mode(HPD_MODE_PARALLEL, 1'b0, 1'b0, 1'b0);
    hw_check();
    chk("pending", 16'h0000, 16'(rq.size() + dq.size()));
    print_verdict();
  end

  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end
endmodule : host_port_pin_decode_tb_top
`default_nettype wire
